// File: hw/timer8_core.sv
`timescale 1ns/10ps
module timer8_core (
    input wire logic mclk,
    input wire logic rst_b,
    input timer8_pkg::bus_req_type bus_req,
    output logic [7:0] rdata,
    input wire logic external_count_pin,
    input wire logic global_irq_enable,
    input timer8_pkg::irq_group_type vector_ack,
    output timer8_pkg::irq_group_type irq_req,
    output logic wave_out_a,
    output logic wave_out_a_en,
    output logic wave_out_b,
    output logic wave_out_b_en
);
    import timer8_pkg::*;

    logic [7:0] timer_control_a_reg;
    logic [3:0] timer_control_b_reg;
    logic [7:0] counter_value_reg;
    logic [7:0] counter_value_next;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic [2:0] timer_interrupt_mask_reg;
    logic [2:0] timer_interrupt_flags_reg;
    logic [2:0] flags_next;
    logic count_down_reg;
    logic count_down_next;
    logic block_match_reg;
    logic [2:0] pin_sync_reg;
    logic [7:0] rdata_reg;
    logic prescale_tick;

    wire wr_control_a = bus_req.wr && bus_req.addr == CONTROL_A_OFFSET;
    wire wr_control_b = bus_req.wr && bus_req.addr == CONTROL_B_OFFSET;
    wire wr_counter = bus_req.wr && bus_req.addr == COUNTER_OFFSET;
    wire wr_compare_a = bus_req.wr && bus_req.addr == COMPARE_A_OFFSET;
    wire wr_compare_b = bus_req.wr && bus_req.addr == COMPARE_B_OFFSET;
    wire wr_mask = bus_req.wr && bus_req.addr == MASK_OFFSET;
    wire wr_flags = bus_req.wr && bus_req.addr == FLAGS_OFFSET;

    wire [2:0] clock_select_field =
        timer_control_b_reg[CLOCK_SELECT_MSB:0];
    wire wave_mode_high_bit = timer_control_b_reg[WAVE_HIGH_BIT];
    wire [1:0] wave_mode_low_bits = timer_control_a_reg[1:0];
    wire [2:0] wave_mode = {wave_mode_high_bit, wave_mode_low_bits};
    wire [1:0] output_mode_a =
        timer_control_a_reg[OUTPUT_MODE_A_LSB +: 2];
    wire [1:0] output_mode_b =
        timer_control_a_reg[OUTPUT_MODE_B_LSB +: 2];
    wire mode_fast = wave_mode == WM_FAST_MAX ||
                     wave_mode == WM_FAST_TOP_A;
    wire mode_phase = wave_mode == WM_PC_MAX ||
                      wave_mode == WM_PC_TOP_A;
    // the reserved mode codes fall through as non-PWM counting
    wire mode_top_a = wave_mode == WM_CTC ||
                      wave_mode == WM_PC_TOP_A ||
                      wave_mode == WM_FAST_TOP_A;
    wire [7:0] top_value = mode_top_a ? compare_value_a_reg : COUNT_MAX;

    // ---------------------------------------------------------------
    // force strobes, live only in non-PWM modes
    // ---------------------------------------------------------------
    wire pwm_active = mode_fast | mode_phase;
    wire force_a = wr_control_b && bus_req.wdata[FORCE_A_BIT] &&
                   !pwm_active;
    wire force_b = wr_control_b && bus_req.wdata[FORCE_B_BIT] &&
                   !pwm_active;

    // ---------------------------------------------------------------
    // clock source
    // ---------------------------------------------------------------
    timer8_prescaler #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescaler (
        .mclk(mclk),
        .rst_b(rst_b),
        .clock_select_field(clock_select_field),
        .tick(prescale_tick)
    );

    // stage 0 is read only by stage 1; edges come from stages 1 and 2
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_count_pin};
        end
    end

    // the pin is sampled as an input whatever its direction
    wire pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];
    wire pin_fall = ~pin_sync_reg[1] & pin_sync_reg[2];
    wire ext_tick = (clock_select_field == CS_EXT_FALL && pin_fall) ||
                    (clock_select_field == CS_EXT_RISE && pin_rise);
    wire timer_tick = prescale_tick | ext_tick;

    // ---------------------------------------------------------------
    // compare and count
    // ---------------------------------------------------------------
    wire equal_a = counter_value_reg == compare_value_a_reg;
    wire equal_b = counter_value_reg == compare_value_b_reg;
    wire tick_ok = timer_tick && !block_match_reg;
    wire match_a = tick_ok && equal_a;
    wire match_b = tick_ok && equal_b;
    wire at_top = counter_value_reg == top_value;
    wire at_bottom = counter_value_reg == COUNT_BOTTOM;

    always_comb begin
        counter_value_next = counter_value_reg;
        count_down_next = count_down_reg;
        if (wr_counter) begin
            counter_value_next = bus_req.wdata;
        end else if (timer_tick) begin
            if (mode_phase) begin
                if (!count_down_reg && at_top) begin
                    count_down_next = 1'b1;
                    counter_value_next = counter_value_reg - 8'h01;
                end else if (count_down_reg && at_bottom) begin
                    count_down_next = 1'b0;
                    counter_value_next = counter_value_reg + 8'h01;
                end else if (count_down_reg) begin
                    counter_value_next = counter_value_reg - 8'h01;
                end else begin
                    counter_value_next = counter_value_reg + 8'h01;
                end
            end else if (at_top) begin
                // forced strobes never reach here, only a timer tick with the counter at top_value
                counter_value_next = COUNT_BOTTOM;
                count_down_next = 1'b0;
            end else begin
                counter_value_next = counter_value_reg + 8'h01;
                count_down_next = 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt flags
    // ---------------------------------------------------------------
    wire overflow_event = timer_tick && (
        (mode_phase && count_down_reg && at_bottom) ||
        (wave_mode == WM_FAST_TOP_A && at_top) ||
        (!mode_phase && wave_mode != WM_FAST_TOP_A &&
         counter_value_reg == COUNT_MAX));
    wire [2:0] flag_set;
    wire [2:0] flag_clear;
    assign flag_set[COMPARE_B_BIT] = match_b;
    assign flag_set[COMPARE_A_BIT] = match_a;
    assign flag_set[OVERFLOW_BIT] = overflow_event;
    assign flag_clear[COMPARE_B_BIT] = vector_ack.compare_b |
        (wr_flags & bus_req.wdata[COMPARE_B_BIT]);
    assign flag_clear[COMPARE_A_BIT] = vector_ack.compare_a |
        (wr_flags & bus_req.wdata[COMPARE_A_BIT]);
    assign flag_clear[OVERFLOW_BIT] = vector_ack.overflow |
        (wr_flags & bus_req.wdata[OVERFLOW_BIT]);

    // a set in the same cycle as a clear wins
    assign flags_next = (timer_interrupt_flags_reg & ~flag_clear) |
                        flag_set;

    wire [2:0] irq_raw = timer_interrupt_flags_reg &
        timer_interrupt_mask_reg & {3{global_irq_enable}};
    assign irq_req.compare_b = irq_raw[COMPARE_B_BIT];
    assign irq_req.compare_a = irq_raw[COMPARE_A_BIT];
    assign irq_req.overflow = irq_raw[OVERFLOW_BIT];

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timer_control_a_reg <= REG_RESET;
            timer_control_b_reg <= REG_RESET[3:0];
            compare_value_a_reg <= REG_RESET;
            compare_value_b_reg <= REG_RESET;
            timer_interrupt_mask_reg <= REG_RESET[2:0];
        end else begin
            if (wr_control_a) begin
                timer_control_a_reg <= bus_req.wdata & CONTROL_A_MASK;
            end
            if (wr_control_b) begin
                // force bits are strobes and are not stored
                timer_control_b_reg <= bus_req.wdata[3:0];
            end
            if (wr_compare_a) begin
                compare_value_a_reg <= bus_req.wdata;
            end
            if (wr_compare_b) begin
                compare_value_b_reg <= bus_req.wdata;
            end
            if (wr_mask) begin
                timer_interrupt_mask_reg <= bus_req.wdata[2:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            counter_value_reg <= REG_RESET;
            count_down_reg <= 1'b0;
            block_match_reg <= 1'b0;
            timer_interrupt_flags_reg <= REG_RESET[2:0];
        end else begin
            counter_value_reg <= counter_value_next;
            count_down_reg <= count_down_next;
            // held through the next timer tick, whose compare match it suppresses
            block_match_reg <= wr_counter |
                (block_match_reg & ~timer_tick);
            timer_interrupt_flags_reg <= flags_next;
        end
    end

    // ---------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ---------------------------------------------------------------
    logic [7:0] read_mux;
    always_comb begin
        case (bus_req.addr)
            CONTROL_A_OFFSET: read_mux = timer_control_a_reg;
            CONTROL_B_OFFSET: read_mux = {4'h0, timer_control_b_reg};
            COUNTER_OFFSET: read_mux = counter_value_reg;
            COMPARE_A_OFFSET: read_mux = compare_value_a_reg;
            COMPARE_B_OFFSET: read_mux = compare_value_b_reg;
            MASK_OFFSET: read_mux = {5'h00, timer_interrupt_mask_reg};
            FLAGS_OFFSET: read_mux = {5'h00, timer_interrupt_flags_reg};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_req.rd ? read_mux : 8'h00;
        end
    end
    assign rdata = rdata_reg;

    timer8_wave_channel u_channel_a (
        .mclk(mclk),
        .rst_b(rst_b),
        .output_mode(output_mode_a),
        .pwm_fast(mode_fast),
        .pwm_phase(mode_phase),
        .toggle_allowed(wave_mode_high_bit),
        .match(match_a),
        .force_match(force_a),
        .at_bottom(timer_tick && at_bottom && !count_down_reg),
        .count_down(count_down_reg),
        .wave_out(wave_out_a),
        .wave_en(wave_out_a_en)
    );

    timer8_wave_channel u_channel_b (
        .mclk(mclk),
        .rst_b(rst_b),
        .output_mode(output_mode_b),
        .pwm_fast(mode_fast),
        .pwm_phase(mode_phase),
        .toggle_allowed(1'b0),
        .match(match_b),
        .force_match(force_b),
        .at_bottom(timer_tick && at_bottom && !count_down_reg),
        .count_down(count_down_reg),
        .wave_out(wave_out_b),
        .wave_en(wave_out_b_en)
    );
endmodule // timer8_core

// File: shared/timer8_pkg.sv
// Behaviour
// - force bit A applies immediate compare on A, in non-PWM modes only
// - force bit B applies immediate compare on B, in non-PWM modes only
// - forced compare A sets no flag, no clear
// - forced compare B sets no flag, no clear
// - force bits are strobes, read as zero
// - clock select stops, divides 1/8/64/256/1024
// - select 110 falling, 111 rising pin edges
// - pin edges count even when pin output
// - counter read/write; write blocks next match
// - compare registers matched against counter continuously
// - enable, flag and global bit raise request
// - compare B flag sets on match, vector or one clears
// - compare A flag, vector or one clears
// - overflow flag per mode, vector or one clears
// - reserved bits read back as zero
// - mode high bit joins low bits for sequence
// - overflow at max, bottom or top per mode
// - non-PWM output modes toggle, clear, set
package timer8_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] FLAGS_OFFSET = 8'h15;
    localparam logic [7:0] CONTROL_A_OFFSET = 8'h24;
    localparam logic [7:0] CONTROL_B_OFFSET = 8'h25;
    localparam logic [7:0] COUNTER_OFFSET = 8'h26;
    localparam logic [7:0] COMPARE_A_OFFSET = 8'h27;
    localparam logic [7:0] COMPARE_B_OFFSET = 8'h28;
    localparam logic [7:0] MASK_OFFSET = 8'h6E;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int WAVE_HIGH_BIT = 3;
    localparam int CLOCK_SELECT_MSB = 2;
    localparam int OUTPUT_MODE_A_LSB = 6;
    localparam int OUTPUT_MODE_B_LSB = 4;
    localparam int COMPARE_B_BIT = 2;
    localparam int COMPARE_A_BIT = 1;
    localparam int OVERFLOW_BIT = 0;

    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] CONTROL_A_MASK = 8'hF3;
    localparam logic [7:0] CONTROL_B_READ_MASK = 8'h0F;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h07;
    localparam int PRESCALE_WIDTH = 10;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_MAX = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PC_TOP_A = 3'h5;
    localparam logic [2:0] WM_FAST_TOP_A = 3'h7;

    localparam logic [1:0] OM_PORT = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic compare_b;
        logic compare_a;
        logic overflow;
    } irq_group_type;

endpackage

// File: hw/timer8_prescaler.sv
`timescale 1ns/10ps
module timer8_prescaler #(
    parameter int WIDTH = timer8_pkg::PRESCALE_WIDTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [2:0] clock_select_field,
    output logic tick
);
    import timer8_pkg::*;

    generate
        if (WIDTH < 10) begin : g_bad_width
            $error("prescaler needs at least 10 bits for divide by 1024");
        end
    endgenerate

    logic [WIDTH-1:0] div_reg;
    wire tap_8 = &div_reg[2:0];
    wire tap_64 = &div_reg[5:0];
    wire tap_256 = &div_reg[7:0];
    wire tap_1024 = &div_reg[9:0];

    // free running, so a new select takes effect at the next tap
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_comb begin
        case (clock_select_field)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = tap_8;
            CS_DIV64: tick = tap_64;
            CS_DIV256: tick = tap_256;
            CS_DIV1024: tick = tap_1024;
            default: tick = 1'b0;
        endcase
    end
endmodule // timer8_prescaler

// File: hw/timer8_wave_channel.sv
`timescale 1ns/10ps
module timer8_wave_channel (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] output_mode,
    input wire logic pwm_fast,
    input wire logic pwm_phase,
    input wire logic toggle_allowed,
    input wire logic match,
    input wire logic force_match,
    input wire logic at_bottom,
    input wire logic count_down,
    output logic wave_out,
    output logic wave_en
);
    import timer8_pkg::*;

    logic wave_reg;
    logic wave_next;
    wire pwm = pwm_fast | pwm_phase;
    wire hit = match | (force_match & ~pwm);

    always_comb begin
        wave_next = wave_reg;
        if (!pwm) begin
            if (hit) begin
                case (output_mode)
                    OM_TOGGLE: wave_next = ~wave_reg;
                    OM_CLEAR: wave_next = 1'b0;
                    OM_SET: wave_next = 1'b1;
                    default: wave_next = wave_reg;
                endcase
            end
        end else if (output_mode == OM_TOGGLE) begin
            if (toggle_allowed && match) begin
                wave_next = ~wave_reg;
            end
        end else if (output_mode != OM_PORT) begin
            if (pwm_fast && at_bottom) begin
                wave_next = (output_mode == OM_CLEAR);
            end else if (match) begin
                wave_next = (output_mode == OM_CLEAR) ? count_down
                                                      : ~count_down;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= wave_next;
        end
    end

    assign wave_out = wave_reg;
    assign wave_en = (output_mode != OM_PORT) &&
                     !(pwm && output_mode == OM_TOGGLE && !toggle_allowed);
endmodule // timer8_wave_channel

// File: sim/timer8_core_sva.sv
`timescale 1ns/10ps
module timer8_core_sva (
    input wire logic mclk,
    input wire logic rst_b,
    input timer8_pkg::bus_req_type bus_req,
    input wire logic [7:0] rdata,
    input wire logic external_count_pin,
    input wire logic global_irq_enable,
    input timer8_pkg::irq_group_type vector_ack,
    input timer8_pkg::irq_group_type irq_req,
    input wire logic wave_out_a,
    input wire logic wave_out_a_en,
    input wire logic wave_out_b,
    input wire logic wave_out_b_en
);
    import timer8_pkg::*;
    logic [7:0] ca_reg;
    logic [3:0] cb_reg;
    logic [2:0] msk_reg;
    wire wr_b = bus_req.wr && bus_req.addr == CONTROL_B_OFFSET;
    wire wr_f = bus_req.wr && bus_req.addr == FLAGS_OFFSET;
    wire stopped = cb_reg[2:0] == CS_STOP;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ca_reg <= 8'h00;
            cb_reg <= 4'h0;
            msk_reg <= 3'h0;
        end else begin
            if (bus_req.wr && bus_req.addr == CONTROL_A_OFFSET)
                ca_reg <= bus_req.wdata;
            if (wr_b)
                cb_reg <= bus_req.wdata[3:0];
            if (bus_req.wr && bus_req.addr == MASK_OFFSET)
                msk_reg <= bus_req.wdata[2:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_ctl_b_read: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == CONTROL_B_OFFSET
        |-> rdata == {4'h0, $past(cb_reg)}) else $error("ctl b read");
    a_mask_read: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == MASK_OFFSET
        |-> rdata == {5'h00, $past(msk_reg)}) else $error("mask read");
    a_flag_reserved: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == FLAGS_OFFSET
        |-> rdata[7:3] == 5'h00) else $error("flag reserved");
    a_irq_global: assert property (
        !global_irq_enable |-> irq_req == 3'h0) else $error("irq gate");
    a_irq_mask: assert property (
        ({irq_req} & ~msk_reg) == 3'h0) else $error("irq mask");
    a_flag_w1c: assert property (
        stopped && wr_f && bus_req.wdata[1:0] == 2'h3
        |=> !irq_req.overflow && !irq_req.compare_a) else $error("w1c");
    a_force_noflag: assert property (
        stopped && wr_b && bus_req.wdata[2:0] == CS_STOP
        && vector_ack == 3'h0 |=> $stable(irq_req)) else $error("force");
    a_force_toggle: assert property (
        stopped && wr_b && bus_req.wdata[FORCE_A_BIT] && !ca_reg[0]
        && ca_reg[7:6] == OM_TOGGLE
        |-> ##[1:2] wave_out_a != $past(wave_out_a)) else $error("fa");
    a_force_set_b: assert property (
        stopped && wr_b && bus_req.wdata[FORCE_B_BIT] && !ca_reg[0]
        && ca_reg[5:4] == OM_SET |-> ##[1:2] wave_out_b) else $error("fb");
    a_out_enable: assert property (
        !ca_reg[0] && $stable(ca_reg)
        |-> wave_out_a_en == (ca_reg[7:6] != OM_PORT)
        && wave_out_b_en == (ca_reg[5:4] != OM_PORT)) else $error("oe");
    c_cmp_a: cover property (irq_req.compare_a);
    c_ovf: cover property (irq_req.overflow);
    c_force: cover property (wr_b && bus_req.wdata[FORCE_A_BIT]);
endmodule // timer8_core_sva

bind timer8_core timer8_core_sva u_sva (.mclk(mclk), .rst_b(rst_b),
    .bus_req(bus_req), .rdata(rdata),
    .external_count_pin(external_count_pin),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .irq_req(irq_req), .wave_out_a(wave_out_a),
    .wave_out_a_en(wave_out_a_en), .wave_out_b(wave_out_b),
    .wave_out_b_en(wave_out_b_en));

// File: sim/timer8_pin_model.sv
`timescale 1ns/10ps
module timer8_pin_model (
    input wire logic mclk,
    input wire logic start,
    input wire logic [7:0] pulses,
    input wire logic [3:0] gap,
    output logic external_count_pin,
    output logic busy
);
    initial begin
        external_count_pin = 1'b0;
        busy = 1'b0;
    end
    // each level is held gap cycles so the synchroniser cannot miss it
    always @(posedge mclk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < pulses; i++) begin
                repeat (gap) @(posedge mclk);
                external_count_pin <= 1'b1;
                repeat (gap) @(posedge mclk);
                external_count_pin <= 1'b0;
            end
            busy <= 1'b0;
        end
    end
endmodule // timer8_pin_model

// File: sim/timer8_control_status_regs_test.sv
`timescale 1ns/10ps
module timer8_control_status_regs_test;
    import timer8_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    bus_req_type bus_req = '0;
    logic global_irq_enable = 1'b0;
    irq_group_type vector_ack = '0;
    irq_group_type irq_req;
    logic [7:0] rdata;
    logic [7:0] pin_n = 8'h00;
    logic [3:0] pin_gap = 4'h4;
    logic pin_start = 1'b0;
    logic ext_pin, pin_busy, wa, wa_en, wb, wb_en;
    int miscompares = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    timer8_core DUT (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
        .rdata(rdata), .external_count_pin(ext_pin),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .irq_req(irq_req), .wave_out_a(wa), .wave_out_a_en(wa_en),
        .wave_out_b(wb), .wave_out_b_en(wb_en));
    timer8_pin_model u_pins (.mclk(mclk), .start(pin_start),
        .pulses(pin_n), .gap(pin_gap), .external_count_pin(ext_pin),
        .busy(pin_busy));
    task automatic check(input logic [7:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic ack(input irq_group_type k);
        @(posedge mclk);
        vector_ack <= k;
        @(posedge mclk);
        vector_ack <= '0;
    endtask
    task automatic t_regs();
        logic [7:0] v;
        logic [7:0] offs [6] = '{CONTROL_B_OFFSET, COMPARE_B_OFFSET,
            MASK_OFFSET, COUNTER_OFFSET, COMPARE_A_OFFSET, FLAGS_OFFSET};
        foreach (offs[i]) begin
            rd(offs[i], v);
            check(v, REG_RESET, "reset");
        end
        wr(CONTROL_B_OFFSET, 8'hF8);
        rd(CONTROL_B_OFFSET, v);
        check(v, 8'h08, "ctl b");
        wr(MASK_OFFSET, 8'hFF);
        rd(MASK_OFFSET, v);
        check(v, 8'h07, "mask");
        wr(CONTROL_B_OFFSET, 8'h00);
        wr(8'h30, 8'hFF);
        rd(8'h30, v);
        check(v, 8'h00, "unmapped");
    endtask
    task automatic t_force();
        logic [7:0] v;
        logic w;
        w = wa;
        wr(CONTROL_A_OFFSET, {OM_TOGGLE, OM_SET, 4'h0});
        wr(CONTROL_B_OFFSET, 8'h80);
        #1 check(wa, !w, "force a");
        wr(CONTROL_B_OFFSET, 8'h40);
        #1 check(wb, 1'b1, "force b");
        wr(COUNTER_OFFSET, 8'h05);
        wr(COMPARE_A_OFFSET, 8'h05);
        wr(CONTROL_A_OFFSET, {OM_CLEAR, OM_CLEAR, 4'h2});
        wr(CONTROL_B_OFFSET, 8'hC0);
        #1 check({wa, wb, wa_en}, 3'h1, "force clr");
        rd(COUNTER_OFFSET, v);
        check(v, 8'h05, "no clear");
        rd(FLAGS_OFFSET, v);
        check(v, 8'h00, "no flag");
        wr(CONTROL_A_OFFSET, {OM_CLEAR, OM_SET, 4'h3});
        wr(CONTROL_B_OFFSET, 8'h00);
        check({wa, wb, wa_en, wb_en}, 4'h3, "pwm");
        wr(CONTROL_A_OFFSET, 8'h00);
    endtask
    task automatic t_match();
        logic [7:0] v;
        wr(COMPARE_A_OFFSET, 8'h10);
        wr(COMPARE_B_OFFSET, 8'h40);
        wr(COUNTER_OFFSET, 8'h00);
        wr(CONTROL_B_OFFSET, {5'h00, CS_DIV1});
        repeat (24) @(posedge mclk);
        wr(CONTROL_B_OFFSET, 8'h00);
        rd(FLAGS_OFFSET, v);
        check(v, 8'h02, "cmp a");
        check(irq_req, 3'h0, "gated");
        global_irq_enable <= 1'b1;
        @(posedge mclk);
        check(irq_req, 3'h2, "irq a");
        ack('{compare_b: 1'b0, compare_a: 1'b1, overflow: 1'b0});
        rd(FLAGS_OFFSET, v);
        check(v, 8'h00, "ack a");
        wr(COMPARE_B_OFFSET, 8'h02);
        wr(COUNTER_OFFSET, 8'hFE);
        wr(CONTROL_B_OFFSET, {5'h00, CS_DIV1});
        repeat (8) @(posedge mclk);
        wr(CONTROL_B_OFFSET, 8'h00);
        rd(FLAGS_OFFSET, v);
        check(v, 8'h05, "ovf cmp b");
        check(irq_req, 3'h5, "irq");
        ack('{compare_b: 1'b1, compare_a: 1'b0, overflow: 1'b0});
        wr(FLAGS_OFFSET, 8'h03);
        rd(FLAGS_OFFSET, v);
        check(v, 8'h00, "clear");
        wr(COMPARE_A_OFFSET, 8'h20);
        wr(COUNTER_OFFSET, 8'h80);
        wr(CONTROL_B_OFFSET, {5'h00, CS_DIV1});
        wr(COUNTER_OFFSET, 8'h20);
        repeat (4) @(posedge mclk);
        wr(CONTROL_B_OFFSET, 8'h00);
        rd(FLAGS_OFFSET, v);
        check(v, 8'h00, "blocked");
        rd(COUNTER_OFFSET, v);
        check(v > 8'h20 && v < 8'h30, 1'b1, "cnt");
    endtask
    task automatic t_clocks();
        logic [7:0] v;
        int divs [4] = '{8, 64, 256, 1024};
        for (int i = 0; i < 4; i++) begin
            wr(COUNTER_OFFSET, 8'h00);
            wr(CONTROL_B_OFFSET, {5'h00, CS_DIV8 + 3'(i)});
            repeat (divs[i] * 4) @(posedge mclk);
            wr(CONTROL_B_OFFSET, 8'h00);
            rd(COUNTER_OFFSET, v);
            check(v >= 8'h04 && v <= 8'h05, 1'b1, "div");
        end
        repeat (30) @(posedge mclk);
        wr(COUNTER_OFFSET, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(CONTROL_B_OFFSET, {5'h00, i ? CS_EXT_FALL : CS_EXT_RISE});
            pin_n <= i ? 8'h03 : 8'h05;
            pin_gap <= i ? 4'h9 : 4'h4;
            pin_start <= 1'b1;
            @(posedge mclk);
            pin_start <= 1'b0;
            #1;
            repeat (200) if (pin_busy) @(posedge mclk);
            repeat (6) @(posedge mclk);
            rd(COUNTER_OFFSET, v);
            check(v, i ? 8'h08 : 8'h05, "ext");
        end
        wr(CONTROL_B_OFFSET, 8'h00);
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_force();
        t_match();
        t_clocks();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results();
    end
endmodule // timer8_control_status_regs_test
